//--- logic/hfmt_map.svh
// Register map, field positions, reset values and line constants
// Contract
// R1: An eight-bit address field follows the opening flag, passed untouched. The code takes it as one character of the configured width.
// R2: An eight-bit control field follows the address, passed untouched. The code takes it as one character of the configured width.
// R3: Information field may have any length, including none at all.
// R4: A 16-bit check covers all bits between opening flag and check field.
// R5: Stuffed zeros never enter the check, on either direction.
// R6: One flag may close a frame and open the next.
// R7: Frames under 48 bits including flags are not presented as valid.
// R8: No maximum frame length is imposed by the device.
// R9: Byte mode sends sync fill and finds sync on receive by itself.
// R10: Bit mode stuffs and removes zeros without host help.
// R11: Character length is selectable from one to eight bits.
// R12: Check is CRC-16, CCITT preset zero, CCITT preset one, or none.
// R13: Point-to-point, multi-drop or loop link is host selectable.
// R14: Host opens a frame by command; device then sends an opening flag.
// R15: Host closes a frame after the last character; device sends closing flag.
// R16: On close the device appends its own check before the closing flag.
// R17: Receiver flags frame start when a frame begins after a flag.
// R18: Receiver flags frame end when the terminating flag arrives.
// R19: Received characters reach the host in line order.
// R20: Host writes and reads characters of the configured width.
// R21: Behaviour is the same whichever bus master drives the registers.
// R22: Frames are delimited by the pattern zero, six ones, zero.
// R23: A zero follows every five ones sent; receiver deletes it.
// R24: A check mismatch at frame end sets a readable error bit.
// R25: CCITT uses x16+x12+x5+1; CRC-16 uses x16+x15+x2+1.
`ifndef HFMT_MAP_SVH
`define HFMT_MAP_SVH
`define HFMT_OFS_CTRL 8'h00
`define HFMT_OFS_SYNC 8'h04
`define HFMT_OFS_TXD 8'h08
`define HFMT_OFS_CMD 8'h0C
`define HFMT_OFS_STAT 8'h10
`define HFMT_OFS_RXD 8'h14
`define HFMT_CMD_OPEN 0
`define HFMT_CMD_CLOSE 1
`define HFMT_STAT_STICKY 7:2
`define HFMT_ST_OPEN 0
`define HFMT_ST_CLOSE 1
`define HFMT_ST_CRC 2
`define HFMT_ST_SHORT 3
`define HFMT_ST_OVR 4
`define HFMT_ST_UNDR 5
`define HFMT_SYNC_RST 8'h00
`define HFMT_FLAG 8'h7E
`define HFMT_BCAST 8'hFF
`define HFMT_POLY_C16 16'h8005
`define HFMT_POLY_CCITT 16'h1021
`define HFMT_PRESET_ONE 16'hFFFF
`define HFMT_FLAG_BITS 5'h08
`define HFMT_FCS_BITS 5'h10
`define HFMT_MIN_BITS 6'h20
`define HFMT_STUFF_RUN 3'h5
`define HFMT_FLAG_RUN 3'h6
`define HFMT_WORD_SIZE 3'h2
`endif

//--- logic/hfmt_pkg.sv
// Types shared by the frame formatter
package hfmt_pkg;
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_FLAG = 4'h2,
    TX_DATA = 4'h4,
    TX_FCS = 4'h8
  } hfmt_tx_e;
  typedef enum logic [1:0] {
    check_none = 2'h0,
    check_crc16 = 2'h1,
    ccitt_check_preset_zero = 2'h2,
    ccitt_check_preset_one = 2'h3
  } hfmt_chk_e;
  typedef enum logic [1:0] {
    link_point = 2'h0,
    link_multidrop = 2'h1,
    link_loop = 2'h2,
    link_spare = 2'h3
  } hfmt_link_e;
  // Control register image, bit 7 down to bit 0
  typedef struct packed {
    hfmt_link_e link;
    logic [2:0] len;
    hfmt_chk_e chk;
    logic byte_oriented_mode;
  } hfmt_ctrl_s;
  // Whole state of the core
  typedef struct packed {
    hfmt_ctrl_s ctrl;
    logic [7:0] sync;
    logic [7:0] hold;
    logic hold_full, open_pend, close_pend;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    logic ls1, ls2, ls3, rs1, rs2;
    hfmt_tx_e tst;
    logic [15:0] tsh, tcrc;
    logic [4:0] tcnt;
    logic [2:0] tones;
    logic fr_open, fr_data, txd;
    logic [2:0] rones, fill;
    logic [6:0] pipe;
    logic hunt, infr, skip, first, rvalid;
    logic [7:0] rsh, rbuf;
    logic [3:0] rcnt;
    logic [15:0] rcrc;
    logic [5:0] blen, sticky;
  } hfmt_state_s;
endpackage : hfmt_pkg

//--- logic/hfmt_top.sv
// Frame formatter core: register slave, transmitter and receiver
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`include "hfmt_map.svh"
module hfmt_top (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // High for write
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready in
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Response, always OKAY
  input wire logic line_clk, // Bit clock from the line
  input wire logic line_rxd, // Serial receive data
  output logic line_txd // Serial transmit data
);

  hfmt_pkg::hfmt_state_s r;
  hfmt_pkg::hfmt_state_s next_r;

  logic tx_tick;
  logic rx_tick;
  logic ld_data;
  logic dlv;
  logic bytem;
  logic bt;
  logic rb;
  logic cb;
  logic commit;
  logic tstuff;
  logic [3:0] nbits;
  logic [7:0] mask;
  logic [7:0] cv;
  logic [7:0] rv;
  logic [5:0] set;
  logic [5:0] clr;
  logic [15:0] pre;

  // One serial step of either check polynomial
  function automatic logic [15:0] crc_step(input logic [15:0] c,
      input logic b, input hfmt_pkg::hfmt_chk_e k);
    logic [15:0] p;
    p = (k == hfmt_pkg::check_crc16) ? `HFMT_POLY_C16 : `HFMT_POLY_CCITT;
    return {c[14:0], 1'b0} ^ ((b ^ c[15]) ? p : 16'h0000);
  endfunction : crc_step

  // Outputs; the slave never waits except while the core is frozen
  assign hrdata = r.rdata;
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign line_txd = r.txd;

  // Next-state logic for the whole core
  always_comb begin
    next_r = r;
    set = 6'h00;
    clr = 6'h00;
    ld_data = 1'b0;
    dlv = 1'b0;
    commit = 1'b0;
    cb = 1'b0;
    rv = 8'h00;
    bytem = r.ctrl.byte_oriented_mode;
    nbits = {1'b0, r.ctrl.len} + 4'h1; // R11 R20
    mask = 8'hFF >> (4'h8 - nbits);
    pre = (r.ctrl.chk == hfmt_pkg::ccitt_check_preset_one) ?
        `HFMT_PRESET_ONE : 16'h0000; // R12 R25

    // Line clock and data pass two flops before use
    next_r.ls1 = line_clk;
    next_r.ls2 = r.ls1;
    next_r.ls3 = r.ls2;
    next_r.rs1 = line_rxd;
    next_r.rs2 = r.rs1;
    tx_tick = r.ls3 & ~r.ls2;
    rx_tick = ~r.ls3 & r.ls2;
    rb = r.rs2;

    // Address phase: capture writes, answer reads at once
    next_r.dp_wr = 1'b0;
    if (hsel && htrans[1] && hready && hsize == `HFMT_WORD_SIZE) begin // R21
      next_r.dp_addr = haddr[7:0];
      next_r.dp_wr = hwrite;
      if (!hwrite) begin
        case (haddr[7:0])
          `HFMT_OFS_CTRL: rv = r.ctrl;
          `HFMT_OFS_SYNC: rv = r.sync;
          `HFMT_OFS_RXD: begin
            rv = r.rbuf;
            next_r.rvalid = 1'b0;
          end
          default: rv = 8'h00;
        endcase
        next_r.rdata = {24'h00_0000, rv};
        if (haddr[7:0] == `HFMT_OFS_STAT) begin
          next_r.rdata = {23'h00_0000, ~r.hunt, r.sticky, r.rvalid,
              ~r.hold_full};
        end
      end
    end

    // Receiver, one step per rising line clock edge
    cv = 8'h00;
    if (rx_tick) begin
      if (bytem) begin
        // Byte mode: hunt for sync, then frame characters
        next_r.rsh = {rb, r.rsh[7:1]};
        cv = 8'((next_r.rsh >> (4'h8 - nbits)));
        if (r.hunt) begin
          if (cv == (r.sync & mask)) begin // R9
            next_r.hunt = 1'b0;
            next_r.rcnt = 4'h0;
          end
        end else begin
          next_r.rcnt = r.rcnt + 4'h1;
          if (next_r.rcnt == nbits) begin
            next_r.rcnt = 4'h0;
            dlv = (cv != (r.sync & mask)); // R9
          end
        end
      end else begin
        // Bit mode: watch runs of ones on the raw line
        if (rb) begin
          if (r.rones == `HFMT_FLAG_RUN) begin
            // Seventh one is an abort: drop frame and hunt
            next_r.hunt = 1'b1; // R22
            next_r.fill = 3'h0;
            next_r.infr = 1'b0;
          end else begin
            next_r.rones = r.rones + 3'h1;
            commit = 1'b1;
          end
        end else begin
          next_r.rones = 3'h0;
          if (r.rones == `HFMT_FLAG_RUN) begin
            // Flag seen: close the frame in progress, open the next
            if (!r.hunt && r.infr && !r.skip) begin // R6
              if (r.blen < `HFMT_MIN_BITS) begin
                set[`HFMT_ST_SHORT] = 1'b1; // R7
              end else begin
                set[`HFMT_ST_CLOSE] = 1'b1; // R18
                if (r.ctrl.chk != hfmt_pkg::check_none &&
                    r.rcrc != 16'h0000) begin
                  set[`HFMT_ST_CRC] = 1'b1; // R24
                end
              end
            end
            next_r.hunt = 1'b0; // R22
            next_r.fill = 3'h0;
            next_r.infr = 1'b0;
            next_r.skip = 1'b0;
            next_r.first = 1'b1;
            next_r.rcrc = pre;
            next_r.blen = 6'h00;
            next_r.rcnt = 4'h0;
          end else if (r.rones != `HFMT_STUFF_RUN) begin
            commit = 1'b1;
          end
          // A zero after five ones is a stuffed bit and is dropped
        end
        // Seven-bit pipe holds back bits until they cannot be a flag
        if (commit) begin
          next_r.pipe = {r.pipe[5:0], rb};
          if (r.fill != 3'h7) begin
            next_r.fill = r.fill + 3'h1;
            commit = 1'b0;
          end else begin
            cb = r.pipe[6];
            commit = !r.hunt;
          end
        end
        if (commit) begin
          next_r.infr = 1'b1;
          next_r.rcrc = crc_step(r.rcrc, cb, r.ctrl.chk); // R4 R5
          if (r.blen != 6'h3F) begin
            next_r.blen = r.blen + 6'h01; // R8
          end
          next_r.rsh = {cb, r.rsh[7:1]};
          cv = 8'((next_r.rsh >> (4'h8 - nbits)));
          next_r.rcnt = r.rcnt + 4'h1;
          if (next_r.rcnt == nbits) begin
            next_r.rcnt = 4'h0;
            if (r.first) begin
              // Address character decides whether this station listens
              next_r.first = 1'b0;
              if (r.ctrl.link == hfmt_pkg::link_multidrop &&
                  cv != r.sync && cv != `HFMT_BCAST) begin // R13
                next_r.skip = 1'b1;
              end else begin
                set[`HFMT_ST_OPEN] = 1'b1; // R17
              end
            end
            dlv = !next_r.skip; // R1 R2 R3 R19
          end
        end
      end
    end

    // Hand a finished character to the host
    if (dlv) begin
      next_r.rbuf = cv & mask;
      if (r.rvalid && next_r.rvalid) begin
        set[`HFMT_ST_OVR] = 1'b1;
      end
      next_r.rvalid = 1'b1;
    end

    // Transmitter, one bit per falling line clock edge
    tstuff = !bytem && (r.tst == hfmt_pkg::TX_DATA ||
        r.tst == hfmt_pkg::TX_FCS);
    bt = 1'b1;
    if (tx_tick) begin
      if (tstuff && r.tones == `HFMT_STUFF_RUN) begin
        // Stuffed zero: no shift, no check update
        next_r.txd = 1'b0; // R10 R23 R5
        next_r.tones = 3'h0;
      end else begin
        if (r.tcnt == 5'h00) begin
          // Pick the next item to send
          next_r.tst = hfmt_pkg::TX_IDLE;
          next_r.tsh = 16'hFFFF;
          next_r.tcnt = 5'h01;
          if (bytem) begin
            if (r.fr_open && r.hold_full) begin
              ld_data = 1'b1;
            end else if (r.fr_open && r.close_pend) begin
              next_r.fr_open = 1'b0;
              next_r.close_pend = 1'b0;
            end else if (r.fr_open || r.open_pend) begin
              // Sync fill on open, then whenever no character or close waits
              next_r.fr_open = 1'b1; // R9
              next_r.open_pend = 1'b0;
              next_r.tst = hfmt_pkg::TX_DATA;
              next_r.tsh = {8'h00, r.sync};
              next_r.tcnt = {1'b0, nbits};
            end
          end else if (r.fr_open) begin
            if (r.hold_full) begin
              ld_data = 1'b1;
            end else if (r.close_pend &&
                r.ctrl.chk != hfmt_pkg::check_none &&
                r.tst != hfmt_pkg::TX_FCS) begin
              next_r.tst = hfmt_pkg::TX_FCS; // R16
              next_r.tsh = r.tcrc;
              next_r.tcnt = `HFMT_FCS_BITS;
            end else begin
              next_r.tst = hfmt_pkg::TX_FLAG;
              next_r.tsh = {8'h00, `HFMT_FLAG};
              next_r.tcnt = `HFMT_FLAG_BITS;
              if (r.close_pend) begin
                // Closing flag also opens a waiting frame
                next_r.close_pend = 1'b0; // R15
                next_r.fr_open = r.open_pend; // R6
                next_r.open_pend = 1'b0;
                next_r.tcrc = pre;
                next_r.fr_data = 1'b0;
              end else if (r.fr_data) begin
                // Host ran dry mid-frame: end it with a flag
                next_r.fr_open = 1'b0;
                set[`HFMT_ST_UNDR] = 1'b1;
              end
            end
          end else if (r.open_pend) begin
            next_r.tst = hfmt_pkg::TX_FLAG; // R14 R22
            next_r.tsh = {8'h00, `HFMT_FLAG};
            next_r.tcnt = `HFMT_FLAG_BITS;
            next_r.fr_open = 1'b1;
            next_r.open_pend = 1'b0;
            next_r.tcrc = pre;
            next_r.fr_data = 1'b0;
          end
          if (ld_data) begin
            next_r.tst = hfmt_pkg::TX_DATA;
            next_r.tsh = {8'h00, r.hold};
            next_r.tcnt = {1'b0, nbits}; // R11 R20
            next_r.hold_full = 1'b0;
            next_r.fr_data = 1'b1;
          end
        end
        // Data goes out low bit first, the check high bit first
        if (next_r.tst == hfmt_pkg::TX_FCS) begin
          bt = next_r.tsh[15];
          next_r.tsh = {next_r.tsh[14:0], 1'b0};
        end else begin
          bt = next_r.tsh[0];
          next_r.tsh = {1'b0, next_r.tsh[15:1]};
        end
        next_r.txd = bt;
        if (next_r.tst == hfmt_pkg::TX_IDLE &&
            r.ctrl.link == hfmt_pkg::link_loop) begin
          next_r.txd = r.rs2; // R13
        end
        next_r.tcnt = next_r.tcnt - 5'h01;
        if (next_r.tst == hfmt_pkg::TX_DATA && !bytem) begin
          next_r.tcrc = crc_step(next_r.tcrc, bt, r.ctrl.chk); // R4 R25
        end
        next_r.tones = 3'h0;
        if ((next_r.tst == hfmt_pkg::TX_DATA ||
            next_r.tst == hfmt_pkg::TX_FCS) && bt) begin
          next_r.tones = r.tones + 3'h1; // R23
        end
      end
    end

    // Data phase writes come last so that software sets win
    if (r.dp_wr) begin
      case (r.dp_addr)
        `HFMT_OFS_CTRL: begin
          next_r.ctrl = hfmt_pkg::hfmt_ctrl_s'(hwdata[7:0]); // R12
          next_r.hunt = 1'b1;
          next_r.fill = 3'h0;
        end
        `HFMT_OFS_SYNC: next_r.sync = hwdata[7:0];
        `HFMT_OFS_TXD: begin
          // A write into a full holding register is dropped
          if (!r.hold_full) begin
            next_r.hold = hwdata[7:0] & mask;
            next_r.hold_full = 1'b1;
          end
        end
        `HFMT_OFS_CMD: begin
          if (hwdata[`HFMT_CMD_OPEN]) begin
            next_r.open_pend = 1'b1; // R14
          end
          if (hwdata[`HFMT_CMD_CLOSE]) begin
            next_r.close_pend = 1'b1; // R15
          end
        end
        `HFMT_OFS_STAT: clr = hwdata[`HFMT_STAT_STICKY];
        default: ;
      endcase
    end

    // Sticky status: a new event beats a clear in the same cycle
    next_r.sticky = (r.sticky & ~clr) | set;
  end

  // The one state register; reset values are constants only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.sync <= `HFMT_SYNC_RST;
      r.tst <= hfmt_pkg::TX_IDLE;
      r.tsh <= 16'hFFFF;
      r.txd <= 1'b1;
      r.hunt <= 1'b1;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // Opening flag only when the host asked for one
  chk_open_flag_cause: assert property ( // R14
    @(posedge hclk) disable iff (!hresetn)
    ce && tx_tick && !bytem && r.tcnt == 5'h00 && !r.fr_open &&
    next_r.tst == hfmt_pkg::TX_FLAG |-> r.open_pend)
    else $error("opening flag sent without open command");

  // A frame ends only on close or on underrun
  chk_close_flag_cause: assert property ( // R15
    @(posedge hclk) disable iff (!hresetn)
    ce && !bytem && r.fr_open && !next_r.fr_open |->
    r.close_pend || next_r.sticky[`HFMT_ST_UNDR])
    else $error("frame closed without close command");

  // Check field starts only after close with nothing left to send
  chk_fcs_after_close: assert property ( // R16
    @(posedge hclk) disable iff (!hresetn)
    ce && tx_tick && r.tcnt == 5'h00 && r.tst != hfmt_pkg::TX_FCS &&
    next_r.tst == hfmt_pkg::TX_FCS |-> r.close_pend && !r.hold_full)
    else $error("check field sent without close command");

  // Five ones in a frame are followed by a zero on the line
  chk_stuff_zero: assert property ( // R23
    @(posedge hclk) disable iff (!hresetn)
    ce && tx_tick && tstuff && r.tones == `HFMT_STUFF_RUN |=>
    !line_txd && r.tones == 3'h0)
    else $error("missing stuffed zero after five ones");

  // A character load leaves the count at the configured width less the bit sent with it
  chk_char_width: assert property ( // R11
    @(posedge hclk) disable iff (!hresetn)
    ce && ld_data && !r.dp_wr |=> r.tcnt == {2'b00, $past(r.ctrl.len)})
    else $error("transmit character width wrong");

  // End of frame is reported only for long enough frames
  chk_short_frame: assert property ( // R7
    @(posedge hclk) disable iff (!hresetn)
    ce && !r.sticky[`HFMT_ST_CLOSE] && next_r.sticky[`HFMT_ST_CLOSE] |->
    r.blen >= `HFMT_MIN_BITS)
    else $error("short frame reported as complete");

  // Check error follows only a nonzero residue
  chk_crc_error: assert property ( // R24
    @(posedge hclk) disable iff (!hresetn)
    ce && !r.sticky[`HFMT_ST_CRC] && next_r.sticky[`HFMT_ST_CRC] |->
    r.rcrc != 16'h0000 && r.ctrl.chk != hfmt_pkg::check_none)
    else $error("check error without mismatch");

  // Start status comes with the first character of a frame
  chk_open_status: assert property ( // R17
    @(posedge hclk) disable iff (!hresetn)
    ce && !r.sticky[`HFMT_ST_OPEN] && next_r.sticky[`HFMT_ST_OPEN] |->
    dlv && r.first)
    else $error("frame start status without first character");

  // Seven ones abort the frame and restart the hunt
  chk_abort_hunt: assert property ( // R22
    @(posedge hclk) disable iff (!hresetn)
    ce && rx_tick && !bytem && r.rones == `HFMT_FLAG_RUN && r.rs2 |=>
    r.hunt && r.fill == 3'h0)
    else $error("abort did not restart flag hunt");

  // Byte-mode transmitter with a frame open and nothing waiting fills with sync characters
  chk_sync_fill: assert property ( // R9
    @(posedge hclk) disable iff (!hresetn)
    ce && tx_tick && bytem && r.tcnt == 5'h00 && r.fr_open &&
    !r.hold_full && !r.close_pend |=> r.tst == hfmt_pkg::TX_DATA)
    else $error("byte mode did not send sync fill");

endmodule : hfmt_top

//--- testbench/hfmt_remote.sv
// Far-end station model: modem bit clock and remote loopback of the line
module hfmt_remote (
  input wire logic run, // Bit clock runs while high
  input wire logic flip, // Inverts echoed bits while high
  input wire logic line_txd, // Serial data from the formatter
  output logic line_clk, // Bit clock to the formatter
  output logic line_rxd // Serial data to the formatter
);
  timeunit 1ns;
  timeprecision 1ps;

  // Line starts at mark with the clock low
  initial begin
    line_rxd = 1'b1;
  end

  // Clock parks low between frames; odd start offset keeps it unrelated
  initial begin
    line_clk = 1'b0;
    #3;
    forever begin
      #40;
      if (run || line_clk) begin
        line_clk = ~line_clk;
      end
    end
  end

  // Echo the bit just ended so it is stable before the next rising edge
  always @(negedge line_clk) begin
    line_rxd <= line_txd ^ flip;
  end
endmodule : hfmt_remote

//--- testbench/testbench.sv
// Self-checking bench: register access and frames looped back by the remote
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout, hresp, line_clk, line_rxd, line_txd;
  logic run = 1'b0;
  logic flip = 1'b0;
  logic ce = 1'b1;
  int nb, nw;
  int failures = 0;
  int n_tests = 0;
  logic [7:0] dat [6] = '{8'hA5, 8'h13, 8'hFF, 8'h00, 8'h00, 8'h7E};
  logic wq [$];
  logic [31:0] rd, st;

  hfmt_top u_hfmt_top (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .line_clk(line_clk),
    .line_rxd(line_rxd), .line_txd(line_txd));
  hfmt_remote u_hfmt_remote (.run(run), .flip(flip), .line_txd(line_txd),
    .line_clk(line_clk), .line_rxd(line_rxd));

  // System clock, 100 MHz
  always #5 hclk = ~hclk;

  // Record each line bit at its end, as the far end sees it
  always @(negedge line_clk) begin
    if (run) begin
      wq.push_back(line_txd);
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task results;
    $display("failures %0d comparisons %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  // One single word transfer; waits on ready, never on a cycle count
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  // Check sequence over the first n characters, bits taken LSB first
  function automatic logic [15:0] fcs(input logic [1:0] chk, input int n);
    logic [15:0] c;
    logic fb;
    c = (chk == 2'h3) ? 16'hFFFF : 16'h0000;
    for (int i = 0; i < n; i++) begin
      for (int j = 0; j < 8; j++) begin
        fb = c[15] ^ dat[i][j];
        c = {c[14:0], 1'b0};
        if (fb) begin
          c = c ^ ((chk == 2'h1) ? 16'h8005 : 16'h1021);
        end
      end
    end
    return c;
  endfunction : fcs

  function automatic logic [7:0] get8(input int k);
    logic [7:0] b;
    for (int j = 0; j < 8; j++) begin
      b[j] = wq[k + j];
    end
    return b;
  endfunction : get8

  // Rebuild the stuffed bit stream and compare it with the wire
  task wire_chk(input int n, input logic [15:0] c);
    logic e [$];
    int k, m, nerr;
    e = {};
    m = 0;
    for (int i = 0; i < n * 8 + 16; i++) begin
      e.push_back(i < n * 8 ? dat[i / 8][i % 8] : c[15 - (i - n * 8)]);
      m = e[$] ? m + 1 : 0;
      if (m == 5) begin
        e.push_back(1'b0);
        m = 0;
      end
    end
    k = 0;
    while (k < wq.size() && wq[k] === 1'b1) k++;
    check(get8(k), 32'h0000_007E);
    while (get8(k) === 8'h7E) k += 8;
    nerr = 0;
    foreach (e[i]) if (wq[k + i] !== e[i]) nerr++;
    check(nerr, 0);
    check(get8(k + e.size()), 32'h0000_007E);
  endtask : wire_chk

  // Send n characters, collect what comes back, return final status
  task frame(input logic [1:0] chk, input int n, input logic bad,
             output logic [31:0] s);
    logic [7:0] rq [$];
    logic [15:0] c;
    logic [15:0] cr;
    int i;
    i = 0;
    rq = {};
    wq = {};
    run <= 1'b1;
    ahb(1'b1, 8'h00, {24'h00_0000, 2'h0, 3'h7, chk, 1'b0}, s);
    ahb(1'b1, 8'h0C, 32'h0000_0001, s);
    s = 32'h0000_0000;
    while (s[3] !== 1'b1 && s[5] !== 1'b1) begin
      ahb(1'b0, 8'h10, 32'h0000_0000, s);
      if (s[1] === 1'b1) begin
        ahb(1'b0, 8'h14, 32'h0000_0000, rd);
        rq.push_back(rd[7:0]);
      end
      if (s[0] === 1'b1 && i < n) begin
        // Flip one bit of a zero character: no run of ones can appear
        if (bad && i == 4) begin
          flip <= 1'b1;
          repeat (8) @(posedge hclk);
          flip <= 1'b0;
        end
        ahb(1'b1, 8'h08, {24'h00_0000, dat[i]}, rd);
        i++;
        if (i == n) ahb(1'b1, 8'h0C, 32'h0000_0002, rd);
      end
    end
    run <= 1'b0;
    c = fcs(chk, n);
    if (!bad && n > 1) begin
      check(rq.size(), n + ((chk != 2'h0) ? 2 : 0));
      for (int k = 0; k < n; k++) check(rq[k], dat[k]);
      if (chk != 2'h0) begin
        // Check bytes arrive high bit first, so they read reversed
        cr = {<<{c}};
        check(rq[n], cr[7:0]);
        check(rq[n + 1], cr[15:8]);
      end
      if (chk == 2'h3 && n == 6) wire_chk(n, c);
    end
    ahb(1'b1, 8'h10, 32'h0000_00FC, rd);
  endtask : frame

  // Main sequence
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 8'h00, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    ahb(1'b0, 8'h10, 32'h0000_0000, rd);
    check(rd, 32'h0000_0001);
    ahb(1'b1, 8'h04, 32'h0000_005A, rd);
    // Frozen core holds ready low; the read must wait it out
    ce <= 1'b0;
    fork
      ahb(1'b0, 8'h04, 32'h0000_0000, rd);
      begin
        repeat (4) @(posedge hclk);
        ce <= 1'b1;
      end
    join
    check(rd, 32'h0000_005A);
    check(hresp, 1'b0);
    ahb(1'b0, 8'h18, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    // Every check kind, with stuffing and a flag-like character inside
    for (int m = 0; m < 4; m++) begin
      frame(m[1:0], 6, 1'b0, st);
      check(st[5:2], 32'h0000_0003);
    end
    frame(2'h3, 6, 1'b1, st);
    check(st[4], 32'h0000_0001);
    // Exactly 48 bits with no information field is still valid
    frame(2'h3, 2, 1'b0, st);
    check(st[5:2], 32'h0000_0003);
    frame(2'h3, 1, 1'b0, st);
    check(st[5:3], 32'h0000_0004);
    // Byte mode: sync fill between characters, stripped on receive
    run <= 1'b1;
    ahb(1'b1, 8'h00, 32'h0000_0039, rd);
    repeat (100) @(posedge hclk);
    ahb(1'b1, 8'h0C, 32'h0000_0001, rd);
    nb = 0;
    nw = 0;
    for (int t = 0; t < 500 && nb < 2; t++) begin
      ahb(1'b0, 8'h10, 32'h0000_0000, st);
      if (st[1] === 1'b1) begin
        ahb(1'b0, 8'h14, 32'h0000_0000, rd);
        check(rd, {24'h00_0000, dat[nb]});
        nb++;
      end
      // Second character waits for the first so sync fill goes between
      if (st[0] === 1'b1 && nw < 2 && nw <= nb) begin
        ahb(1'b1, 8'h08, {24'h00_0000, dat[nw]}, rd);
        nw++;
      end
    end
    ahb(1'b1, 8'h0C, 32'h0000_0002, rd);
    run <= 1'b0;
    check(nb, 2);
    check(st[8], 1'b1);
    results();
  end

  // Seven frames need well under 100 us; this only cuts a hang short
  initial begin
    #200us;
    failures++;
    results();
  end
endmodule : testbench
